// ===== core/cam_core.sv
/*
 * Mode and configuration logic of a six-module counter array: shared
 * cycle length, reload bank select, cycle overflow flag, per-module
 * capture, match, toggle, PWM and frequency output.
 * Assumes the main counter and its advance pulse come from the timebase
 * on the same clock; capture pins are asynchronous.
 */
// Functional notes
// R1: reload select steers compare byte accesses
// R2: reload values used only in 9-11 bit PWM
// R3: overflow enable gates overflow flag interrupt
// R4: overflow flag from bit chosen by length
// R5: overflow flag set by hardware, software clears
// R6: config bits 4:2 read zero, writes ignored
// R7: length field 00/01/10 gives 8/9/10 bits
// R8: length applies to non-16-bit PWM modules
// R9: wide bit picks 16-bit over short PWM
// R10: compare enable turns on compare function
// R11: rising edge capture when enabled
// R12: falling edge capture when enabled
// R13: match sets module event flag
// R14: toggle inverts pin on each match
// R15: PWM enable drives modulated waveform on pin
// R16: toggle plus PWM gives frequency output
// R17: module irq enable gates event flag
// R18: watchdog enable locks module 5 mode; low/high byte writes still switch its compare enable
// R19: low byte write clears compare enable
// R20: high byte write sets compare enable
// R21: event flag held until software clears
// R22: all enabled requests merge into one irq
// R23: all configuration resets to zero
`include "cam_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module cam_core import cam_pkg::*; (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register bus
  input wire cam_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  // timebase
  input wire logic [15:0] main_counter_i,
  input wire logic counter_tick_i,
  input wire logic watchdog_enable_i,
  // flags
  input wire logic [5:0] flag_clear_i,
  output logic [5:0] module_event_flag_o,
  output logic cycle_overflow_flag_o,
  output logic irq_o,
  // module pins
  input wire logic [5:0] module_io_pin_i,
  output logic [5:0] module_io_pin_o,
  output logic [5:0] module_io_oe_o
);
  localparam logic [7:0] MODE_ADDR [6] = '{`CAM_ADDR_MODE0, `CAM_ADDR_MODE1,
    `CAM_ADDR_MODE2, `CAM_ADDR_MODE3, `CAM_ADDR_MODE4, `CAM_ADDR_MODE5};
  localparam logic [7:0] LOW_ADDR [6] = '{`CAM_ADDR_LOW0, `CAM_ADDR_LOW1,
    `CAM_ADDR_LOW2, `CAM_ADDR_LOW3, `CAM_ADDR_LOW4, `CAM_ADDR_LOW5};
  localparam logic [7:0] HIGH_ADDR [6] = '{`CAM_ADDR_HIGH0, `CAM_ADDR_HIGH1,
    `CAM_ADDR_HIGH2, `CAM_ADDR_HIGH3, `CAM_ADDR_HIGH4, `CAM_ADDR_HIGH5};
  // reset image of the shared register; fields taken by position
  localparam logic [7:0] CFG_RST = `CAM_RST_PWM_CFG;

  // shared configuration
  logic reload_bank_select;
  logic cycle_overflow_irq_enable;
  logic cycle_overflow_flag;
  logic [1:0] cycle_length_select;
  logic next_reload_bank_select;
  logic next_cycle_overflow_irq_enable;
  logic next_cycle_overflow_flag;
  logic [1:0] next_cycle_length_select;
  logic [7:0] sfr_rdata;
  logic [7:0] next_sfr_rdata;
  logic [15:0] len_mask;
  logic short_wrap;
  logic full_wrap;
  logic wr_cfg;

  cam_mode_t mode [6];
  logic [15:0] cmp_value [6];
  logic [15:0] reload_value [6];
  logic [5:0] event_flag;
  logic [5:0] pin_out;

  // 11 encoded as 11 bits, beyond the three listed lengths
  always_comb begin
    unique case (cycle_length_select)
      2'b00: len_mask = 16'h00ff; // [R7]
      2'b01: len_mask = 16'h01ff; // [R7]
      2'b10: len_mask = 16'h03ff; // [R7]
      2'b11: len_mask = 16'h07ff;
    endcase
  end

  // counter is already advanced when the tick is seen, so zero means wrap
  assign short_wrap = counter_tick_i && ((main_counter_i & len_mask) == 16'h0000); // [R4]
  assign full_wrap = counter_tick_i && (main_counter_i == 16'h0000);
  assign wr_cfg = sfr_req_i.wr && (sfr_req_i.addr == `CAM_ADDR_PWM_CFG);

  always_comb begin
    next_reload_bank_select = reload_bank_select;
    next_cycle_overflow_irq_enable = cycle_overflow_irq_enable;
    next_cycle_overflow_flag = cycle_overflow_flag;
    next_cycle_length_select = cycle_length_select;
    if (wr_cfg) begin
      // bits 4:2 are not stored
      next_reload_bank_select = sfr_req_i.wdata[`CAM_BIT_RELOAD_SEL]; // [R6]
      next_cycle_overflow_irq_enable = sfr_req_i.wdata[`CAM_BIT_OVF_IRQ_EN];
      next_cycle_overflow_flag = sfr_req_i.wdata[`CAM_BIT_OVF_FLAG]; // [R5]
      next_cycle_length_select = sfr_req_i.wdata[`CAM_POS_CYCLE_LEN +: 2];
    end
    // hardware set wins over a simultaneous software clear
    if (short_wrap) begin
      next_cycle_overflow_flag = 1'b1; // [R4] [R5]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reload_bank_select <= CFG_RST[`CAM_BIT_RELOAD_SEL]; // [R23]
      cycle_overflow_irq_enable <= CFG_RST[`CAM_BIT_OVF_IRQ_EN]; // [R23]
      cycle_overflow_flag <= CFG_RST[`CAM_BIT_OVF_FLAG];
      cycle_length_select <= CFG_RST[`CAM_POS_CYCLE_LEN +: 2]; // [R23]
    end else begin
      reload_bank_select <= next_reload_bank_select;
      cycle_overflow_irq_enable <= next_cycle_overflow_irq_enable;
      cycle_overflow_flag <= next_cycle_overflow_flag;
      cycle_length_select <= next_cycle_length_select;
    end
  end

  // read data is registered; reads have no side effects here
  always_comb begin
    next_sfr_rdata = 8'h00;
    if (sfr_req_i.addr == `CAM_ADDR_PWM_CFG) begin
      next_sfr_rdata = {reload_bank_select, cycle_overflow_irq_enable,
        cycle_overflow_flag, 3'b000, cycle_length_select}; // [R6]
    end
    for (int k = 0; k < 6; k++) begin
      if (sfr_req_i.addr == MODE_ADDR[k]) begin
        next_sfr_rdata = mode[k];
      end
      if (sfr_req_i.addr == LOW_ADDR[k]) begin
        next_sfr_rdata = reload_bank_select ? reload_value[k][7:0] : cmp_value[k][7:0]; // [R1]
      end
      if (sfr_req_i.addr == HIGH_ADDR[k]) begin
        next_sfr_rdata = reload_bank_select ? reload_value[k][15:8] : cmp_value[k][15:8]; // [R1]
      end
    end
    if (!sfr_req_i.rd) begin
      next_sfr_rdata = sfr_rdata;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // one slice per module; slices share the bus, the counter and the shared configuration
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_mod
      // stages 0 and 1 synchronise, stage 2 holds the previous level
      logic [2:0] pin_sync;
      logic [2:0] next_pin_sync;
      cam_mode_t next_mode;
      logic [15:0] next_cmp;
      logic [15:0] next_reload;
      logic next_flag;
      logic next_pin;
      cam_kind_t kind;
      logic wr_mode;
      logic wr_low;
      logic wr_high;
      logic rise;
      logic fall;
      logic captured;
      logic hit;
      logic [15:0] hit_mask;

      assign wr_mode = sfr_req_i.wr && (sfr_req_i.addr == MODE_ADDR[i]);
      assign wr_low = sfr_req_i.wr && (sfr_req_i.addr == LOW_ADDR[i]);
      assign wr_high = sfr_req_i.wr && (sfr_req_i.addr == HIGH_ADDR[i]);
      // edges read only the second and third stages
      assign rise = pin_sync[1] && !pin_sync[2];
      assign fall = !pin_sync[1] && pin_sync[2];
      assign captured = (rise && mode[i].rising_capture_enable) || // [R11]
        (fall && mode[i].falling_capture_enable); // [R12]

      // output modes come first; capture only while the pin is an input
      always_comb begin
        if (mode[i].pulse_width_enable && mode[i].toggle_enable) begin
          kind = CAM_FREQ_OUT; // [R16]
        end else if (mode[i].pulse_width_enable) begin
          kind = mode[i].wide_pwm_enable ? CAM_PWM_WIDE : CAM_PWM_SHORT; // [R9]
        end else if (mode[i].toggle_enable) begin
          kind = CAM_TOGGLE;
        end else if (mode[i].match_enable) begin
          kind = CAM_MATCH;
        end else if (mode[i].rising_capture_enable || mode[i].falling_capture_enable) begin
          kind = CAM_CAPTURE;
        end else begin
          kind = CAM_IDLE;
        end
      end

      always_comb begin
        unique case (kind)
          CAM_PWM_SHORT: hit_mask = len_mask; // [R8]
          CAM_FREQ_OUT: hit_mask = 16'h00ff;
          default: hit_mask = 16'hffff;
        endcase
      end

      // no compare activity unless the comparator is on
      assign hit = counter_tick_i && mode[i].compare_enable && // [R10]
        ((main_counter_i & hit_mask) == (cmp_value[i] & hit_mask));

      always_comb begin
        next_pin_sync = {pin_sync[1:0], module_io_pin_i[i]};
        next_mode = mode[i];
        next_cmp = cmp_value[i];
        next_reload = reload_value[i];
        next_pin = pin_out[i];

        // locked while module 5 serves as the watchdog
        if (wr_mode && !(i == `CAM_WDOG_MODULE && watchdog_enable_i)) begin
          next_mode = sfr_req_i.wdata; // [R18]
        end
        // byte writes switch the comparator in either bank
        if (wr_low) begin
          if (reload_bank_select) begin
            next_reload[7:0] = sfr_req_i.wdata; // [R1]
          end else begin
            next_cmp[7:0] = sfr_req_i.wdata; // [R1]
          end
          next_mode.compare_enable = 1'b0; // [R19]
        end
        if (wr_high) begin
          if (reload_bank_select) begin
            next_reload[15:8] = sfr_req_i.wdata; // [R1]
          end else begin
            next_cmp[15:8] = sfr_req_i.wdata; // [R1]
          end
          next_mode.compare_enable = 1'b1; // [R20]
        end

        // pin and compare register behaviour of the selected mode
        unique case (kind)
          CAM_CAPTURE: begin
            // snapshot of the counter at the qualified edge
            if (captured) begin
              next_cmp = main_counter_i;
            end
          end
          CAM_TOGGLE: begin
            if (hit) begin
              next_pin = !pin_out[i]; // [R14]
            end
          end
          CAM_FREQ_OUT: begin
            // half period is the high byte
            if (hit) begin
              next_pin = !pin_out[i]; // [R16]
              next_cmp[7:0] = cmp_value[i][7:0] + cmp_value[i][15:8];
            end
          end
          CAM_PWM_SHORT: begin
            // low from the match, high again at the cycle wrap; a match wins
            if (hit) begin
              next_pin = 1'b0; // [R15]
            end else if (short_wrap) begin
              next_pin = 1'b1; // [R15]
              if (cycle_length_select == 2'b00) begin
                next_cmp[7:0] = cmp_value[i][15:8];
              end else begin
                // reload only matters for 9-11 bit cycles
                next_cmp = (cmp_value[i] & ~len_mask) | (reload_value[i] & len_mask); // [R2]
              end
            end
          end
          CAM_PWM_WIDE: begin
            // whole 16-bit cycle; the length select plays no part
            if (hit) begin
              next_pin = 1'b0; // [R15]
            end else if (full_wrap) begin
              next_pin = 1'b1; // [R15]
            end
          end
          default: begin
          end
        endcase

        // a new event in the clear cycle wins, so none is lost
        next_flag = (event_flag[i] && !flag_clear_i[i]) || // [R21]
          (hit && mode[i].match_enable) || // [R13]
          (captured && kind == CAM_CAPTURE);
      end

      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          pin_sync <= 3'b000;
          mode[i] <= `CAM_RST_MODE; // [R23]
          cmp_value[i] <= `CAM_RST_WORD;
          reload_value[i] <= `CAM_RST_WORD;
          event_flag[i] <= 1'b0;
          pin_out[i] <= 1'b0;
        end else begin
          pin_sync <= next_pin_sync;
          mode[i] <= next_mode;
          cmp_value[i] <= next_cmp;
          reload_value[i] <= next_reload;
          event_flag[i] <= next_flag;
          pin_out[i] <= next_pin;
        end
      end

      // capture, match and idle modes leave the pin to the outside
      assign module_io_oe_o[i] = mode[i].toggle_enable || mode[i].pulse_width_enable;
    end
  endgenerate

  assign sfr_rdata_o = sfr_rdata;
  assign module_event_flag_o = event_flag;
  assign cycle_overflow_flag_o = cycle_overflow_flag;
  assign module_io_pin_o = pin_out;

  // one request line for the whole array
  // flags stay set until cleared, so the request is a level
  always_comb begin
    irq_o = cycle_overflow_flag && cycle_overflow_irq_enable; // [R3]
    for (int k = 0; k < 6; k++) begin
      irq_o = irq_o || (event_flag[k] && mode[k].module_flag_irq_enable); // [R17] [R22]
    end
  end
endmodule
`default_nettype wire

// ===== core/cam_defs.svh
/*
 * Addresses, field positions and reset values of the counter array
 * mode and configuration registers.
 * Assumes an 8-bit register bus with an 8-bit address space.
 */
`ifndef CAM_DEFS_SVH
`define CAM_DEFS_SVH
`define CAM_ADDR_PWM_CFG 8'hdf
`define CAM_ADDR_MODE0 8'hda
`define CAM_ADDR_MODE1 8'hdb
`define CAM_ADDR_MODE2 8'hdc
`define CAM_ADDR_MODE3 8'hdd
`define CAM_ADDR_MODE4 8'hde
`define CAM_ADDR_MODE5 8'hce
`define CAM_ADDR_LOW0 8'hfb
`define CAM_ADDR_LOW1 8'he9
`define CAM_ADDR_LOW2 8'heb
`define CAM_ADDR_LOW3 8'hed
`define CAM_ADDR_LOW4 8'hfd
`define CAM_ADDR_LOW5 8'hd2
`define CAM_ADDR_HIGH0 8'hfc
`define CAM_ADDR_HIGH1 8'hea
`define CAM_ADDR_HIGH2 8'hec
`define CAM_ADDR_HIGH3 8'hee
`define CAM_ADDR_HIGH4 8'hfe
`define CAM_ADDR_HIGH5 8'hd3
`define CAM_BIT_RELOAD_SEL 7
`define CAM_BIT_OVF_IRQ_EN 6
`define CAM_BIT_OVF_FLAG 5
`define CAM_POS_CYCLE_LEN 0
`define CAM_WDOG_MODULE 5
`define CAM_RST_MODE 8'h00
`define CAM_RST_PWM_CFG 8'h00
`define CAM_RST_WORD 16'h0000
`endif

// ===== core/cam_pkg.sv
/*
 * Types of the counter array mode block.
 * Kind codes are set here; no constant is taken from cam_defs.svh.
 */
package cam_pkg;
  typedef struct packed {
    logic wide_pwm_enable;
    logic compare_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pulse_width_enable;
    logic module_flag_irq_enable;
  } cam_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cam_sfr_req_t;

  typedef enum logic [2:0] {
    CAM_IDLE = 3'b000,
    CAM_CAPTURE = 3'b001,
    CAM_MATCH = 3'b010,
    CAM_TOGGLE = 3'b011,
    CAM_PWM_SHORT = 3'b100,
    CAM_PWM_WIDE = 3'b101,
    CAM_FREQ_OUT = 3'b110
  } cam_kind_t;
endpackage

// ===== test/cam_core_asserts.sv
/* port checker for the counter array mode block.
   assumes it is bound into cam_core on one clock. */
`include "cam_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module cam_core_asserts import cam_pkg::*; (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register bus
  input wire cam_sfr_req_t sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  // events and pins
  input wire logic counter_tick_i,
  input wire logic [5:0] flag_clear_i,
  input wire logic [5:0] module_event_flag_o,
  input wire logic cycle_overflow_flag_o,
  input wire logic irq_o,
  input wire logic [5:0] module_io_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic cfg_wr, cfg_set, m0_wr;
  logic [5:0] keep;
  assign cfg_wr = sfr_req_i.wr && sfr_req_i.addr == `CAM_ADDR_PWM_CFG;
  assign cfg_set = cfg_wr && sfr_req_i.wdata[`CAM_BIT_OVF_FLAG];
  assign m0_wr = sfr_req_i.wr && sfr_req_i.addr == `CAM_ADDR_MODE0;
  assign keep = module_event_flag_o & ~flag_clear_i;
  chk_ovf_held: assert property (cycle_overflow_flag_o && !(cfg_wr && !sfr_req_i.wdata[5]) |=> cycle_overflow_flag_o)
    else $error("overflow flag lost");
  chk_ovf_cause: assert property ($rose(cycle_overflow_flag_o) |-> $past(counter_tick_i) || $past(cfg_set))
    else $error("overflow flag without cause");
  chk_flag_held: assert property (1'b1 |=> (module_event_flag_o & $past(keep)) == $past(keep))
    else $error("event flag lost");
  chk_irq_source: assert property (irq_o |-> cycle_overflow_flag_o || |module_event_flag_o)
    else $error("irq without flag");
  chk_rdata_hold: assert property (!sfr_req_i.rd |=> $stable(sfr_rdata_o))
    else $error("read data moved");
  chk_cfg_zero: assert property (sfr_req_i.rd && sfr_req_i.addr == `CAM_ADDR_PWM_CFG |=> sfr_rdata_o[4:2] == 3'h0)
    else $error("unused cfg bits set");
  chk_reset_clear: assert property ($fell(rst_i) |-> sfr_rdata_o == 8'h00 && module_event_flag_o == 6'h00 && !irq_o)
    else $error("outputs not clear after reset");
  chk_oe_toggle: assert property (m0_wr && sfr_req_i.wdata[2] |=> module_io_oe_o[0])
    else $error("toggle mode not driving");
  chk_oe_idle: assert property (m0_wr && sfr_req_i.wdata == 8'h00 |=> !module_io_oe_o[0])
    else $error("idle module driving");
endmodule
bind cam_core cam_core_asserts i_chk (.clock_i(clock_i), .rst_i(rst_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .counter_tick_i(counter_tick_i), .flag_clear_i(flag_clear_i),
  .module_event_flag_o(module_event_flag_o), .cycle_overflow_flag_o(cycle_overflow_flag_o),
  .irq_o(irq_o), .module_io_oe_o(module_io_oe_o));
`default_nettype wire

// ===== test/cam_pin_model.sv
/* outside circuitry on the six module pins.
   assumes the bench calls set_pin; levels move just after an edge. */
`timescale 1ns/1ns
`default_nettype none
module cam_pin_model (
  // clock
  input wire logic clock_i,
  // design side
  input wire logic [5:0] drive_i,
  input wire logic [5:0] oe_i,
  // wire level
  output logic [5:0] level_o
);
  logic [5:0] ext = 6'h00;
  // a driven pin shows the design's level, never the outside one
  assign level_o = (drive_i & oe_i) | (ext & ~oe_i);
  task automatic set_pin(input int idx, input logic val);
    @(posedge clock_i);
    ext[idx] <= val;
  endtask
endmodule
`default_nettype wire

// ===== test/counter_array_module_modes_tb.sv
/* self-checking bench of the counter array mode block.
   assumes cam_core, its checker and the pin model are compiled first. */
`include "cam_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module counter_array_module_modes_tb import cam_pkg::*; ;
  logic clock_i, rst_i, tick, wdog, ovf, irq;
  cam_sfr_req_t req;
  logic [7:0] rdata;
  logic [15:0] count;
  logic [5:0] clr, flag, pin_in, pin_out, oe;
  logic [7:0] maddr [6] = '{`CAM_ADDR_MODE0, `CAM_ADDR_MODE1, `CAM_ADDR_MODE2,
    `CAM_ADDR_MODE3, `CAM_ADDR_MODE4, `CAM_ADDR_MODE5};
  int num_errors = 0;
  int num_checks = 0;
  cam_core i_dut (.clock_i(clock_i), .rst_i(rst_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .main_counter_i(count), .counter_tick_i(tick), .watchdog_enable_i(wdog), .flag_clear_i(clr),
    .module_event_flag_o(flag), .cycle_overflow_flag_o(ovf), .irq_o(irq),
    .module_io_pin_i(pin_in), .module_io_pin_o(pin_out), .module_io_oe_o(oe));
  cam_pin_model i_pins (.clock_i(clock_i), .drive_i(pin_out), .oe_i(oe), .level_o(pin_in));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= '{a, 1'b1, 1'b0, d};
    @(posedge clock_i);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock_i);
    req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clock_i);
    req <= '0;
    #1 chk(rdata, exp, what);
  endtask
  task automatic pulse(input logic [15:0] c);
    @(posedge clock_i);
    count <= c;
    tick <= 1'b1;
    @(posedge clock_i);
    tick <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask
  task automatic clear(input logic [5:0] m);
    @(posedge clock_i);
    clr <= m;
    @(posedge clock_i);
    clr <= 6'h00;
    #1;
  endtask
  // a run needs about 250 cycles; 2000 leaves room without hiding a hang
  initial begin
    #40000;
    num_errors++;
    print_verdict;
  end
  initial begin
    rst_i = 1'b1;
    req = '0;
    count = 16'h0000;
    {tick, wdog, clr} = '0;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`CAM_ADDR_PWM_CFG, 8'h00, "cfg reset");
    rd(8'h00, 8'h00, "unmapped");
    wr(`CAM_ADDR_PWM_CFG, 8'hff);
    rd(`CAM_ADDR_PWM_CFG, 8'he3, "cfg bits");
    chk(irq, 1'b1, "ovf irq");
    wr(`CAM_ADDR_PWM_CFG, 8'h20);
    chk(ovf, 1'b1, "ovf sw set");
    chk(irq, 1'b0, "ovf masked");
    wr(`CAM_ADDR_PWM_CFG, 8'h00);
    chk(ovf, 1'b0, "ovf sw clear");
    foreach (maddr[i]) begin
      rd(maddr[i], 8'h00, "mode reset");
      wr(maddr[i], 8'ha5);
      rd(maddr[i], 8'ha5, "mode rw");
      chk(oe[i], 1'b1, "oe toggle");
      wr(maddr[i], 8'h00);
    end
    @(posedge clock_i);
    wdog <= 1'b1;
    wr(`CAM_ADDR_MODE5, 8'h02);
    rd(`CAM_ADDR_MODE5, 8'h00, "mode5 locked");
    @(posedge clock_i);
    wdog <= 1'b0;
    wr(`CAM_ADDR_MODE5, 8'h02);
    chk(oe[5], 1'b1, "pwm drive");
    wr(`CAM_ADDR_MODE5, 8'h00);
    wr(`CAM_ADDR_HIGH0, 8'h00);
    rd(`CAM_ADDR_MODE0, 8'h40, "high sets cmp");
    wr(`CAM_ADDR_LOW0, 8'h05);
    rd(`CAM_ADDR_MODE0, 8'h00, "low clears cmp");
    wr(`CAM_ADDR_PWM_CFG, 8'h80);
    wr(`CAM_ADDR_LOW0, 8'h33);
    rd(`CAM_ADDR_LOW0, 8'h33, "reload bank");
    wr(`CAM_ADDR_PWM_CFG, 8'h00);
    rd(`CAM_ADDR_LOW0, 8'h05, "compare bank");
    wr(`CAM_ADDR_MODE0, 8'h4d);
    pulse(16'h0004);
    chk(flag[0], 1'b0, "no match");
    pulse(16'h0005);
    chk(flag[0], 1'b1, "match flag");
    chk(pin_out[0], 1'b1, "toggle");
    chk(irq, 1'b1, "flag irq");
    pulse(16'h0006);
    chk(flag[0], 1'b1, "flag held");
    clear(6'h01);
    chk(irq, 1'b0, "flag cleared");
    wr(`CAM_ADDR_MODE0, 8'h4c);
    pulse(16'h0005);
    chk(pin_out[0], 1'b0, "toggle back");
    chk(irq, 1'b0, "flag masked");
    clear(6'h01);
    wr(`CAM_ADDR_LOW0, 8'h05);
    pulse(16'h0005);
    chk(flag[0], 1'b0, "compare off");
    wr(`CAM_ADDR_MODE0, 8'h00);
    wr(`CAM_ADDR_PWM_CFG, 8'h41);
    pulse(16'h0100);
    chk(ovf, 1'b0, "no 9 bit wrap");
    pulse(16'h0200);
    chk(irq, 1'b1, "9 bit wrap");
    wr(`CAM_ADDR_PWM_CFG, 8'h00);
    pulse(16'h0300);
    chk(ovf, 1'b1, "8 bit wrap");
    wr(`CAM_ADDR_PWM_CFG, 8'h00);
    @(posedge clock_i);
    count <= 16'h1234;
    wr(`CAM_ADDR_MODE1, 8'h20);
    i_pins.set_pin(1, 1'b1);
    repeat (6) @(posedge clock_i);
    #1 chk(flag[1], 1'b1, "rising capture");
    rd(`CAM_ADDR_LOW1, 8'h34, "captured low");
    clear(6'h02);
    wr(`CAM_ADDR_MODE1, 8'h10);
    i_pins.set_pin(1, 1'b0);
    repeat (6) @(posedge clock_i);
    #1 chk(flag[1], 1'b1, "falling capture");
    wr(`CAM_ADDR_LOW0, 8'h80);
    wr(`CAM_ADDR_HIGH0, 8'h80);
    wr(`CAM_ADDR_MODE0, 8'h42);
    pulse(16'h0100);
    chk(pin_out[0], 1'b1, "pwm wrap high");
    pulse(16'h0180);
    chk(pin_out[0], 1'b0, "pwm match low");
    wr(`CAM_ADDR_PWM_CFG, 8'h81);
    wr(`CAM_ADDR_LOW0, 8'h40);
    wr(`CAM_ADDR_HIGH0, 8'h01);
    wr(`CAM_ADDR_PWM_CFG, 8'h01);
    pulse(16'h0200);
    rd(`CAM_ADDR_LOW0, 8'h40, "reload low");
    rd(`CAM_ADDR_HIGH0, 8'h81, "reload bit 8");
    pulse(16'h0040);
    chk(pin_out[0], 1'b1, "9 bit no match");
    pulse(16'h0340);
    chk(pin_out[0], 1'b0, "9 bit match");
    wr(`CAM_ADDR_PWM_CFG, 8'h02);
    pulse(16'h0200);
    chk(ovf, 1'b0, "no 10 bit wrap");
    pulse(16'h0400);
    chk(ovf, 1'b1, "10 bit wrap");
    wr(`CAM_ADDR_MODE0, 8'hc2);
    pulse(16'h0140);
    chk(pin_out[0], 1'b1, "wide ignores low");
    pulse(16'h8140);
    chk(pin_out[0], 1'b0, "wide match");
    pulse(16'h0400);
    chk(pin_out[0], 1'b0, "wide no short wrap");
    pulse(16'h0000);
    chk(pin_out[0], 1'b1, "wide wrap");
    wr(`CAM_ADDR_PWM_CFG, 8'h00);
    wr(`CAM_ADDR_LOW0, 8'h10);
    wr(`CAM_ADDR_HIGH0, 8'h20);
    wr(`CAM_ADDR_MODE0, 8'h46);
    pulse(16'h0310);
    chk(pin_out[0], 1'b0, "freq toggle");
    rd(`CAM_ADDR_LOW0, 8'h30, "freq step");
    pulse(16'h0330);
    chk(pin_out[0], 1'b1, "freq toggle back");
    wr(`CAM_ADDR_MODE0, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
